//--- hw/asecc_ctrl.sv
// host-side controller driving the ecc static memory pins
`timescale 1ns/10ps
// Summary of operation
// [RULE1] memory selected only while active-low select low and active-high select high
// [RULE2] write starts when write strobe and combined select are both low
// [RULE3] write ends on first rising edge of strobe or select
// [RULE4] data setup and hold measured from the edge ending the write
// [RULE5] strobe-controlled write with gate low holds strobe for turn-off plus setup
// [RULE6] wait supply settle interval before first access
// [RULE7] error flag valid with read data within access time
// [RULE8] memory sleeps by itself after deselect within sleep delay
// [RULE9] error flag low on a clean read
// [RULE10] error flag high on a corrected read
// [RULE11] memory data lines float while deselected or gate high
// [RULE12] corrected data returned without automatic write back
module asecc_ctrl #(
    parameter int unsigned ADDR_W = asecc_pkg::ADDR_W,
    parameter int unsigned DATA_W = asecc_pkg::DATA_W,
    parameter int unsigned SETTLE_CYC = asecc_pkg::SETTLE_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // user request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    // user answer
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic rsp_corrected,
    output logic write_done,
    // memory pins
    output logic chip_select_active_low,
    output logic chip_select_active_high,
    output logic out_gate_n,
    output logic write_strobe_n,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [DATA_W-1:0] mem_dq_o,
    output logic mem_dq_oe,
    input wire logic [DATA_W-1:0] mem_dq_i,
    input wire logic mem_err_i
);
    localparam logic [15:0] ACC_N = 16'(asecc_pkg::ACCESS_CYC);
    localparam logic [15:0] SLP_N = 16'(asecc_pkg::SLEEP_CYC);
    localparam logic [15:0] WP_N = 16'(asecc_pkg::WPULSE_CYC);
    localparam logic [31:0] SET_N = 32'(SETTLE_CYC);

    // synchronised read data and flag from the pins
    logic [DATA_W:0] pin_sync;
    asecc_sync #(.W(DATA_W + 1)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .din({mem_err_i, mem_dq_i}),
        .dout(pin_sync)
    );

    asecc_pkg::asecc_state_t st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    logic req_ready_q, req_ready_d;
    logic rsp_valid_q, rsp_valid_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic corr_q, corr_d;
    logic wdone_q, wdone_d;
    logic csl_q, csl_d, csh_q, csh_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] dq_q, dq_d;
    logic dqoe_q, dqoe_d;

    // next-state logic; sync adds two cycles, so read waits access plus two
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        req_ready_d = 1'b0;
        rsp_valid_d = 1'b0;
        rdata_d = rdata_q;
        corr_d = corr_q;
        wdone_d = 1'b0;
        csl_d = csl_q;
        csh_d = csh_q;
        oe_n_d = oe_n_q;
        we_n_d = we_n_q;
        addr_d = addr_q;
        dq_d = dq_q;
        dqoe_d = dqoe_q;
        unique case (st_q)
            asecc_pkg::ASECC_WAIT: begin
                // [RULE6] supply settle wait
                if (cnt_q >= SET_N - 32'h1) begin
                    st_d = asecc_pkg::ASECC_IDLE;
                    req_ready_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 32'h1;
                end
            end
            asecc_pkg::ASECC_IDLE: begin
                req_ready_d = 1'b1;
                if (req_valid && req_ready_q) begin
                    req_ready_d = 1'b0;
                    addr_d = req_addr;
                    cnt_d = 32'h0;
                    // [RULE1] select both chip selects
                    csl_d = 1'b0;
                    csh_d = 1'b1;
                    if (req_write) begin
                        // [RULE2] strobe and select low together
                        st_d = asecc_pkg::ASECC_WR;
                        we_n_d = 1'b0;
                        oe_n_d = 1'b1;
                        dq_d = req_wdata;
                        dqoe_d = 1'b1;
                    end else begin
                        st_d = asecc_pkg::ASECC_RD;
                        oe_n_d = 1'b0;
                    end
                end
            end
            asecc_pkg::ASECC_RD: begin
                // [RULE7] sample data and flag after access time
                if (cnt_q >= 32'(ACC_N) + 32'h2) begin
                    rdata_d = pin_sync[DATA_W-1:0];
                    corr_d = pin_sync[DATA_W];
                    rsp_valid_d = 1'b1;
                    oe_n_d = 1'b1;
                    csl_d = 1'b1;
                    csh_d = 1'b0;
                    cnt_d = 32'h0;
                    st_d = asecc_pkg::ASECC_REST;
                end else begin
                    cnt_d = cnt_q + 32'h1;
                end
            end
            asecc_pkg::ASECC_WR: begin
                // [RULE5] strobe width covers turn-off plus setup
                if (cnt_q >= 32'(WP_N) - 32'h1) begin
                    // [RULE3] strobe rise ends the write
                    we_n_d = 1'b1;
                    st_d = asecc_pkg::ASECC_WEND;
                end else begin
                    cnt_d = cnt_q + 32'h1;
                end
            end
            asecc_pkg::ASECC_WEND: begin
                // [RULE4] data held one cycle past the ending edge
                csl_d = 1'b1;
                csh_d = 1'b0;
                dqoe_d = 1'b0;
                wdone_d = 1'b1;
                cnt_d = 32'h0;
                st_d = asecc_pkg::ASECC_REST;
            end
            asecc_pkg::ASECC_REST: begin
                // [RULE8] deselected idle gap lets the memory sleep
                if (cnt_q >= 32'(SLP_N) - 32'h1) begin
                    st_d = asecc_pkg::ASECC_IDLE;
                    req_ready_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 32'h1;
                end
            end
            default: begin
                st_d = asecc_pkg::ASECC_WAIT;
            end
        endcase
    end

    // registers; pins reset deselected with the bus released
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q <= asecc_pkg::ASECC_WAIT;
            cnt_q <= 32'h0;
            req_ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rdata_q <= '0;
            corr_q <= 1'b0;
            wdone_q <= 1'b0;
            csl_q <= 1'b1;
            csh_q <= 1'b0;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            addr_q <= '0;
            dq_q <= '0;
            dqoe_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            req_ready_q <= req_ready_d;
            rsp_valid_q <= rsp_valid_d;
            rdata_q <= rdata_d;
            corr_q <= corr_d;
            wdone_q <= wdone_d;
            csl_q <= csl_d;
            csh_q <= csh_d;
            oe_n_q <= oe_n_d;
            we_n_q <= we_n_d;
            addr_q <= addr_d;
            dq_q <= dq_d;
            dqoe_q <= dqoe_d;
        end
    end

    // outputs straight from flip-flops
    assign req_ready = req_ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rdata_q;
    assign rsp_corrected = corr_q;
    assign write_done = wdone_q;
    assign chip_select_active_low = csl_q;
    assign chip_select_active_high = csh_q;
    assign out_gate_n = oe_n_q;
    assign write_strobe_n = we_n_q;
    assign mem_addr = addr_q;
    assign mem_dq_o = dq_q;
    assign mem_dq_oe = dqoe_q;

    // helper counting cycles of a low strobe
    logic [15:0] wlow_q;
    always_ff @(posedge clock) begin
        if (!rst_n || we_n_q) wlow_q <= 16'h0;
        else wlow_q <= wlow_q + 16'h1;
    end

    property p_no_early_access;
        @(posedge clock) disable iff (!rst_n)
        (st_q == asecc_pkg::ASECC_WAIT) |-> (csl_q && !csh_q);
    endproperty
    a_no_early_access: assert property (p_no_early_access) // [RULE6]
        else $error("memory selected during settle wait");

    property p_strobe_needs_select;
        @(posedge clock) disable iff (!rst_n)
        !we_n_q |-> (!csl_q && csh_q && oe_n_q);
    endproperty
    a_strobe_needs_select: assert property (p_strobe_needs_select) // [RULE2]
        else $error("write strobe low without select");

    property p_strobe_width;
        @(posedge clock) disable iff (!rst_n)
        $rose(we_n_q) |-> ($past(wlow_q) == WP_N - 16'h1);
    endproperty
    a_strobe_width: assert property (p_strobe_width) // [RULE5]
        else $error("write strobe width wrong");

    property p_data_held_past_end;
        @(posedge clock) disable iff (!rst_n)
        $rose(we_n_q) |-> dqoe_q && $stable(dq_q);
    endproperty
    a_data_held_past_end: assert property (p_data_held_past_end) // [RULE4]
        else $error("write data not held at write end");

    property p_write_ends_strobe_first;
        @(posedge clock) disable iff (!rst_n)
        $rose(we_n_q) |=> (csl_q && !csh_q && !dqoe_q && wdone_q);
    endproperty
    a_write_ends_strobe_first: assert property (p_write_ends_strobe_first) // [RULE3]
        else $error("write not closed after strobe rise");

    property p_read_sample_time;
        @(posedge clock) disable iff (!rst_n)
        $fell(oe_n_q) |-> !rsp_valid_q [*4] ##1 rsp_valid_q;
    endproperty
    a_read_sample_time: assert property (p_read_sample_time) // [RULE7]
        else $error("read answer out of window");

    property p_flag_follows_pin;
        @(posedge clock) disable iff (!rst_n)
        rsp_valid_q |-> (rsp_corrected == $past(pin_sync[DATA_W]));
    endproperty
    a_flag_follows_pin: assert property (p_flag_follows_pin) // [RULE10]
        else $error("corrected flag not taken from pin");

    property p_no_write_back;
        @(posedge clock) disable iff (!rst_n)
        rsp_valid_q |-> ##1 we_n_q [*3];
    endproperty
    a_no_write_back: assert property (p_no_write_back) // [RULE12]
        else $error("write after read");

    property p_no_drive_while_reading;
        @(posedge clock) disable iff (!rst_n)
        !oe_n_q |-> !dqoe_q;
    endproperty
    a_no_drive_while_reading: assert property (p_no_drive_while_reading) // [RULE11]
        else $error("bus fight with memory output");

    property p_rest_gap;
        @(posedge clock) disable iff (!rst_n)
        $rose(csl_q) |-> csl_q [*1] ##0 !req_ready_q;
    endproperty
    a_rest_gap: assert property (p_rest_gap) // [RULE8]
        else $error("no deselect gap");

    c_read: cover property (@(posedge clock) rsp_valid_q && !corr_q);
    c_read_corr: cover property (@(posedge clock) rsp_valid_q && corr_q);
    c_write: cover property (@(posedge clock) wdone_q);
endmodule : asecc_ctrl

//--- hw/asecc_pkg.sv
// package of pin timing constants for the memory access controller
package asecc_pkg;
    // clock period in picoseconds (100 MHz)
    localparam int unsigned CLK_PS = 10000;
    // times as printed, in their own units
    localparam int unsigned SUPPLY_SETTLE_WAIT_US = 100;
    localparam int unsigned ADDRESS_ACCESS_TIME_NS = 10;
    localparam int unsigned DESELECT_SLEEP_DELAY_NS = 10;
    localparam int unsigned WRITE_TO_HIGHZ_TIME_NS = 5;
    localparam int unsigned DATA_SETUP_TIME_NS = 5;
    // derived cycle counts; least times round up
    localparam int unsigned SETTLE_CYC = (SUPPLY_SETTLE_WAIT_US * 1000000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned ACCESS_CYC = (ADDRESS_ACCESS_TIME_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned SLEEP_CYC = (DESELECT_SLEEP_DELAY_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned WPULSE_CYC =
        ((WRITE_TO_HIGHZ_TIME_NS + DATA_SETUP_TIME_NS) * 1000 + CLK_PS - 1) / CLK_PS;
    // default widths
    localparam int unsigned ADDR_W = 21;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W = 16;
    // controller states
    typedef enum logic [2:0] {
        ASECC_WAIT = 3'b000,
        ASECC_IDLE = 3'b001,
        ASECC_RD = 3'b010,
        ASECC_WR = 3'b011,
        ASECC_WEND = 3'b100,
        ASECC_REST = 3'b101
    } asecc_state_t;
endpackage : asecc_pkg

//--- hw/asecc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module asecc_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // async in, synced out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s1_d;
    logic [W-1:0] s2_d;

    // first stage feeds only the second stage
    always_comb begin
        s1_d = din;
        s2_d = s1_q;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    assign dout = s2_q;
endmodule : asecc_sync

//--- sim/asecc_sram_model.sv
// behavioural model of the ecc static memory on the far side of the pins
`timescale 1ns/10ps
module asecc_sram_model #(
    parameter int unsigned ADDR_W = 21,
    parameter int unsigned DATA_W = 8,
    parameter int unsigned SETTLE_NS = 100000
) (
    // pins driven by the controller
    input wire logic chip_select_active_low,
    input wire logic chip_select_active_high,
    input wire logic out_gate_n,
    input wire logic write_strobe_n,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] mem_dq_o,
    input wire logic mem_dq_oe,
    // pins driven by the memory
    output logic [DATA_W-1:0] mem_dq_i,
    output logic mem_err_i,
    // state seen by the bench
    output logic asleep,
    output int unsigned viol
);
    // small table of written words, searched by address
    localparam int NSLOT = 8;
    logic [ADDR_W-1:0] slot_addr [NSLOT];
    logic [DATA_W-1:0] slot_data [NSLOT];
    bit slot_used [NSLOT];
    bit slot_bad [NSLOT];
    int unsigned n_used;
    int wk;
    int rk;
    logic sel;
    logic wr;
    logic rd;
    realtime t_wr;
    realtime t_dq;
    assign sel = !chip_select_active_low && chip_select_active_high;
    // write is the overlap of strobe and select
    assign wr = sel && !write_strobe_n;
    assign rd = sel && !out_gate_n && write_strobe_n;
    initial begin
        viol = 0;
        asleep = 1'b1;
        mem_dq_i = '0;
        mem_err_i = 1'b0;
    end
    // slot holding an address, or -1 when it was never written
    function automatic int find(input logic [ADDR_W-1:0] a);
        find = -1;
        for (int i = 0; i < NSLOT; i++) begin
            if (slot_used[i] && slot_addr[i] == a) find = i;
        end
    endfunction : find
    // the bench plants a single-bit fault at one written word
    task automatic inject(input logic [ADDR_W-1:0] a);
        int k;
        k = find(a);
        if (k >= 0) slot_bad[k] = 1'b1;
    endtask : inject
    always @(mem_dq_o) t_dq = $realtime;
    always @(posedge wr) t_wr = $realtime;
    // no combined select (both chip selects active) before the supply settle wait has passed
    always @(posedge sel) begin
        if ($realtime < SETTLE_NS) viol++;
    end
    // store at the first rising edge ending the overlap
    always @(negedge wr) begin
        if ($realtime - t_dq < asecc_pkg::DATA_SETUP_TIME_NS || !mem_dq_oe) viol++;
        if (!out_gate_n && $realtime - t_wr < asecc_pkg::WRITE_TO_HIGHZ_TIME_NS
            + asecc_pkg::DATA_SETUP_TIME_NS) viol++;
        wk = find(mem_addr);
        if (wk < 0 && n_used < NSLOT) begin
            wk = int'(n_used);
            n_used++;
            slot_used[wk] = 1'b1;
            slot_addr[wk] = mem_addr;
        end
        // a fresh write replaces a faulty word; a full table counts as a fault
        if (wk >= 0) begin
            slot_data[wk] = mem_dq_o;
            slot_bad[wk] = 1'b0;
        end else begin
            viol++;
        end
    end
    // flag shares data timing; no write back
    always @(rd, mem_addr) begin
        rk = find(mem_addr);
        if (rd) begin
            mem_dq_i <= #(asecc_pkg::ADDRESS_ACCESS_TIME_NS)
                (rk >= 0 ? slot_data[rk] : mem_addr[DATA_W-1:0]);
            mem_err_i <= #(asecc_pkg::ADDRESS_ACCESS_TIME_NS) (rk >= 0 && slot_bad[rk]);
        end else begin
            // floating pins: show garbage, not the last value
            mem_dq_i <= #(asecc_pkg::WRITE_TO_HIGHZ_TIME_NS) ~mem_dq_i;
            mem_err_i <= #(asecc_pkg::WRITE_TO_HIGHZ_TIME_NS) ~mem_err_i;
        end
    end
    always @(sel) asleep <= #(sel ? 0 : asecc_pkg::DESELECT_SLEEP_DELAY_NS) !sel;
endmodule : asecc_sram_model

//--- sim/asecc_ctrl_bench.sv
// self-checking bench for the memory access controller
`timescale 1ns/10ps
module asecc_ctrl_bench;
    localparam int unsigned SETTLE = 4;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [20:0] req_addr = '0;
    logic [7:0] req_wdata = '0;
    logic req_ready, rsp_valid, rsp_corrected, write_done, csl, csh, gate_n, strobe_n;
    logic [7:0] rsp_rdata, dq_o, dq_i;
    logic [20:0] addr;
    logic dq_oe, err, asleep;
    int unsigned viol;
    int unsigned fails = 0;
    int unsigned n_compared = 0;
    always #5 clock = ~clock;
    asecc_ctrl #(.SETTLE_CYC(SETTLE)) i_asecc_ctrl (.clock(clock), .rst_n(rst_n),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_corrected(rsp_corrected), .write_done(write_done),
        .chip_select_active_low(csl), .chip_select_active_high(csh), .out_gate_n(gate_n),
        .write_strobe_n(strobe_n), .mem_addr(addr), .mem_dq_o(dq_o), .mem_dq_oe(dq_oe),
        .mem_dq_i(dq_i), .mem_err_i(err));
    // supply counts as stable at the reset release edge, 95 ns
    asecc_sram_model #(.SETTLE_NS(95 + SETTLE * 10)) i_asecc_sram_model (
        .chip_select_active_low(csl), .chip_select_active_high(csh), .out_gate_n(gate_n),
        .write_strobe_n(strobe_n), .mem_addr(addr), .mem_dq_o(dq_o), .mem_dq_oe(dq_oe),
        .mem_dq_i(dq_i), .mem_err_i(err), .asleep(asleep), .viol(viol));
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %0b seen %0b", what, exp, got);
        end
    endtask : cmp_bit
    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_byte
    // one request, held until taken; answer waited for under a bound
    task automatic access(input logic w, input logic [20:0] a, input logic [7:0] d);
        int unsigned n;
        int unsigned m;
        int unsigned exp_m;
        n = 0;
        m = 0;
        // take to answer: strobe width plus two, or access plus select and sync
        exp_m = w ? asecc_pkg::WPULSE_CYC + 2 : asecc_pkg::ACCESS_CYC + 4;
        @(posedge clock);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        do begin @(negedge clock); n++; end while (req_ready !== 1'b1 && n < 50);
        @(posedge clock);
        req_valid <= 1'b0;
        do begin
            @(negedge clock);
            n++;
            m++;
        end while ((w ? write_done : rsp_valid) !== 1'b1 && n < 100);
        cmp_bit("answer", 1'b1, w ? write_done : rsp_valid);
        cmp_byte("answer cycles", 8'(exp_m), 8'(m));
    endtask : access
    // pins released and memory asleep after an access
    task automatic check_idle();
        repeat (2) @(negedge clock);
        cmp_bit("select low side", 1'b1, csl);
        cmp_bit("select high side", 1'b0, csh);
        cmp_bit("dq drive", 1'b0, dq_oe);
        cmp_bit("gate idle", 1'b1, gate_n);
        cmp_bit("strobe idle", 1'b1, strobe_n);
        cmp_bit("asleep", 1'b1, asleep);
    endtask : check_idle
    // request held from reset release is refused until the settle wait ends
    task automatic t_settle();
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        req_valid <= 1'b1;
        repeat (SETTLE - 1) begin
            @(negedge clock);
            cmp_bit("ready early", 1'b0, req_ready);
            cmp_bit("select early", 1'b1, csl);
        end
        // drop the refused request on a rising edge, before the wait ends
        @(posedge clock);
        req_valid <= 1'b0;
        access(1'b0, 21'h000005, 8'h00);
        cmp_byte("first read", 8'h05, rsp_rdata);
        $display("test settle done");
    endtask : t_settle
    // boundary addresses written with an idle check after the first, then read back clean
    task automatic t_write_read();
        access(1'b1, 21'h1fffff, 8'ha5);
        check_idle();
        access(1'b1, 21'h000000, 8'h5a);
        access(1'b0, 21'h1fffff, 8'h00);
        cmp_byte("read top", 8'ha5, rsp_rdata);
        cmp_bit("flag top", 1'b0, rsp_corrected);
        access(1'b0, 21'h000000, 8'h00);
        check_idle();
        cmp_byte("read bottom", 8'h5a, rsp_rdata);
        cmp_bit("flag bottom", 1'b0, rsp_corrected);
        $display("test write read done");
    endtask : t_write_read
    // corrected word flagged on every read until rewritten
    task automatic t_corrected();
        access(1'b1, 21'h012345, 8'hc3);
        i_asecc_sram_model.inject(21'h012345);
        repeat (2) begin
            access(1'b0, 21'h012345, 8'h00);
            cmp_byte("corrected data", 8'hc3, rsp_rdata);
            cmp_bit("corrected flag", 1'b1, rsp_corrected);
        end
        access(1'b1, 21'h012345, 8'h3c);
        access(1'b0, 21'h012345, 8'h00);
        cmp_byte("rewritten data", 8'h3c, rsp_rdata);
        cmp_bit("rewritten flag", 1'b0, rsp_corrected);
        $display("test corrected done");
    endtask : t_corrected
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    // watchdog sized well above the under a hundred cycles the tests need
    initial begin
        #(5000 * 10);
        fails++;
        $display("[ERR] watchdog expected finish seen hang");
        test_done();
    end
    initial begin
        t_settle();
        t_write_read();
        t_corrected();
        cmp_bit("host timing clean", 1'b1, viol == 0);
        test_done();
    end
endmodule : asecc_ctrl_bench
